// file: bench/fan_load.sv
// Fan load model: tallies drive on-time over each 255-cycle window.
// Assumes the drive period is 255 core_clk cycles, high = on.
`timescale 1ns/1ns
module fan_load (
  input wire logic core_clk,
  input wire logic drive,
  output logic [8:0] highs
);
  logic [7:0] win_q = 8'h00;
  logic [8:0] acc_q = 9'h000;
  initial highs = 9'h000;
  // Window equals the period, so any phase gives the true on-time
  always @(posedge core_clk) begin
    win_q <= (win_q == 8'hFE) ? 8'h00 : win_q + 8'h01;
    acc_q <= (win_q == 8'hFE) ? 9'h000 : acc_q + {8'h00, drive};
    if (win_q == 8'hFE) highs <= acc_q + {8'h00, drive};
  end
endmodule

// file: bench/fan_mux_properties.sv
// Checker for the fan drive source selector, bound to its ports.
// Assumes single-cycle request strobes on core_clk.
`timescale 1ns/1ns
module fan_mux_properties (
  input wire logic core_clk,
  input wire logic rst,
  input wire fan_mux_pkg::reg_req_t req,
  input wire logic [7:0] rdata,
  input wire logic rvalid,
  input wire fan_mux_pkg::demand_t demand,
  input wire logic [2:0] over_limit,
  input wire logic [2:0] [7:0] ceiling_duty,
  input wire logic [2:0] boost_to_full,
  input wire logic fan_drive_one,
  input wire logic fan_drive_two,
  input wire logic fan_drive_three
);
  logic [2:0] bhv_q;
  logic [8:0] same_q;
  default clocking @(posedge core_clk); endclocking
  default disable iff rst;
  // Mode age; a period and a margin before the output must obey it
  always_ff @(posedge core_clk) begin
    if (rst) begin
      bhv_q <= 3'h4;
      // Reset counts as settled: a disabled drive is low at once
      same_q <= 9'h1FF;
    end else if (req.wr && req.addr == 8'h5C) begin
      bhv_q <= req.wdata[7:5];
      same_q <= 9'h000;
    end else if (same_q != 9'h1FF) begin
      same_q <= same_q + 9'h001;
    end
  end
  chk_read_answer: assert property (req.rd |=> rvalid)
    else $error("no answer after read");
  chk_no_stray: assert property (rvalid |-> $past(req.rd))
    else $error("answer without read");
  chk_rdata_holds: assert property (!rvalid |-> $stable(rdata))
    else $error("read data moved without read");
  chk_unmapped_zero: assert property (req.rd && req.addr == 8'h00 |=>
    rdata == 8'h00)
    else $error("unmapped read not zero");
  chk_reset_quiet: assert property ($fell(rst) |-> !rvalid && !fan_drive_one
    && !fan_drive_two && !fan_drive_three)
    else $error("outputs active out of reset");
  chk_full_high: assert property (bhv_q == 3'h3 && same_q > 9'h12C |->
    fan_drive_one)
    else $error("full speed drive went low");
  chk_off_low: assert property (bhv_q == 3'h4 && same_q > 9'h12C |->
    !fan_drive_one)
    else $error("disabled drive went high");
  chk_manual_store: assert property (bhv_q == 3'h7 && over_limit == 3'h0 &&
    req.wr && req.addr == 8'h30 ##2 req.rd && req.addr == 8'h30 |=>
    rdata == $past(req.wdata, 3))
    else $error("manual duty not stored");
  cover property (bhv_q == 3'h3 && same_q > 9'h12C);
  cover property (bhv_q == 3'h7 && over_limit[0]);
  cover property (req.wr && req.addr == 8'h30);
endmodule
bind fan_drive_source_mux fan_mux_properties chk (
  .core_clk(core_clk),
  .rst(rst),
  .req(req),
  .rdata(rdata),
  .rvalid(rvalid),
  .demand(demand),
  .over_limit(over_limit),
  .ceiling_duty(ceiling_duty),
  .boost_to_full(boost_to_full),
  .fan_drive_one(fan_drive_one),
  .fan_drive_two(fan_drive_two),
  .fan_drive_three(fan_drive_three)
);

// file: bench/tb_top.sv
// Bench: register tasks, mode table and thermal override.
// Assumes the fan load model and the bound checker are compiled.
`timescale 1ns/1ns
module tb_top;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  fan_mux_pkg::reg_req_t req = '0;
  fan_mux_pkg::demand_t demand = '{8'h44, 8'h22, 8'h33};
  logic [2:0] over_limit = 3'h0;
  logic [2:0] [7:0] ceiling_duty = '0;
  logic [2:0] boost_to_full = 3'h0;
  logic [7:0] rdata;
  logic rvalid, fan_drive_one, fan_drive_two, fan_drive_three;
  logic [8:0] highs, highs_two, highs_three;
  logic [7:0] exp_tab [7] = '{8'h44, 8'h22, 8'h33, 8'hFF, 8'h00, 8'h33, 8'h44};
  int err_total = 0;
  int checks = 0;
  int cyc = 0;
  fan_drive_source_mux uut (
    .core_clk(core_clk),
    .rst(rst),
    .req(req),
    .rdata(rdata),
    .rvalid(rvalid),
    .demand(demand),
    .over_limit(over_limit),
    .ceiling_duty(ceiling_duty),
    .boost_to_full(boost_to_full),
    .fan_drive_one(fan_drive_one),
    .fan_drive_two(fan_drive_two),
    .fan_drive_three(fan_drive_three)
  );
  fan_load fan (.core_clk(core_clk), .drive(fan_drive_one), .highs(highs));
  fan_load fan_two (.core_clk(core_clk), .drive(fan_drive_two),
    .highs(highs_two));
  fan_load fan_three (.core_clk(core_clk), .drive(fan_drive_three),
    .highs(highs_three));
  initial forever #25 core_clk = ~core_clk;
  task automatic tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Hang guard well above the roughly 9000 cycles the tests need
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 40000) begin
      err_total++;
      tally_and_finish();
    end
  end
  task automatic cmp(string n, logic [8:0] s, logic [8:0] e);
    checks++;
    if (s !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge core_clk) req <= '{1'b1, 1'b0, a, d};
    @(posedge core_clk) req <= '0;
  endtask
  task automatic chk_rd(logic [7:0] a, logic [7:0] e);
    @(posedge core_clk) req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge core_clk) req <= '0;
    #1 cmp("rvalid", {8'h00, rvalid}, 9'h001);
    cmp($sformatf("reg %h", a), {1'b0, rdata}, {1'b0, e});
  endtask
  task automatic settle;
    repeat (800) @(posedge core_clk);
  endtask
  initial begin
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    for (int i = 0; i < 3; i++) chk_rd(8'h5C + i[7:0], 8'h80);
    chk_rd(8'h00, 8'h00);
    wr(8'h5D, 8'h60);
    wr(8'h5E, 8'h20);
    for (int k = 0; k < 7; k++) begin
      wr(8'h5C, {k[2:0], 5'h00});
      settle();
      chk_rd(8'h30, exp_tab[k]);
      cmp("drive one on-time", highs, {1'b0, exp_tab[k]});
    end
    chk_rd(8'h31, 8'hFF);
    cmp("drive two on-time", highs_two, 9'h0FF);
    chk_rd(8'h32, 8'h22);
    cmp("drive three on-time", highs_three, 9'h022);
    @(posedge core_clk) demand.remote1 <= 8'h50;
    settle();
    chk_rd(8'h30, 8'h50);
    wr(8'h31, 8'h10);
    chk_rd(8'h31, 8'hFF);
    // Host selects manual mode, sets manual duty, then reads it back
    wr(8'h5C, 8'hE0);
    wr(8'h30, 8'h80);
    chk_rd(8'h30, 8'h80);
    settle();
    cmp("manual on-time", highs, 9'h080);
    @(posedge core_clk) begin
      ceiling_duty[0] <= 8'h90;
      over_limit[0] <= 1'b1;
    end
    settle();
    chk_rd(8'h30, 8'h90);
    @(posedge core_clk) boost_to_full[0] <= 1'b1;
    settle();
    chk_rd(8'h30, 8'hFF);
    tally_and_finish();
  end
endmodule

// file: hw/fan_drive_source_mux.sv
// Per-output source selector and pulse-width generator for three fan drives.
// Assumes demands from per-channel calibration stages on core_clk and a
// register port from the management bus interface on the same clock.
// Functional notes
// - Each output has its own behaviour field, config bits 7 to 5.
// - Codes 000, 001, 010 select remote one, local, remote two demand.
// - Code 101 drives the higher of local and remote two demands.
// - Code 110 drives the highest of all three channel demands.
// - Code 011 forces full speed regardless of temperature.
// - Code 100 disables the output; reset value of every field.
// - Code 111 lets duty register writes set output duty directly.
// - Over thermal limit, outputs except disabled ones rise to max or full duty, even manual.
// - Each channel computes its demand independently of its users.
// - Automatic control keeps updating outputs without host action.
// - Duty registers are eight bits, 0 to 100 percent, 0.39 percent steps.
// - Channel demand ramps linearly from floor to full across span.
// - Duty registers read back the applied duty in every mode.
`timescale 1ns/1ns
`include "fan_mux_map.svh"
module fan_drive_source_mux (
  input wire logic core_clk,
  input wire logic rst,
  input wire fan_mux_pkg::reg_req_t req,
  output logic [7:0] rdata,
  output logic rvalid,
  input wire fan_mux_pkg::demand_t demand,
  input wire logic [2:0] over_limit,
  input wire logic [2:0] [7:0] ceiling_duty,
  input wire logic [2:0] boost_to_full,
  output logic fan_drive_one,
  output logic fan_drive_two,
  output logic fan_drive_three
);
  fan_mux_pkg::state_t s_q, s_d;
  logic [2:0][7:0] sel_duty;
  logic [2:0] thermal_limit_signal_hit;
  logic [2:0] is_manual;
  logic [7:0] max_lr2;
  logic [7:0] max_all;

  // Channel demands arrive already ramped per channel; shared by all
  // outputs so one channel may feed several drives.
  always_comb begin
    max_lr2 = (demand.local_ch > demand.remote2) ? demand.local_ch
                                                 : demand.remote2;
    max_all = (max_lr2 > demand.remote1) ? max_lr2 : demand.remote1;
  end

  // Thermal limit pin is asynchronous: two stages before any use
  assign thermal_limit_signal_hit = s_q.thermal_limit_signal_sync;

  for (genvar i = 0; i < `NUM_DRIVES; i++) begin : g_sel
    fan_mux_pkg::behaviour_t b;
    logic [7:0] base;
    logic [7:0] boost;
    logic [7:0] sel;
    assign b = fan_mux_pkg::behaviour_t'(s_q.cfg[i][`BEHAVIOUR_SELECT_HI:`BEHAVIOUR_SELECT_LO]);
    assign boost = boost_to_full[i] ? `DUTY_FULL : ceiling_duty[i];
    assign is_manual[i] = (b == fan_mux_pkg::SRC_MANUAL);
    assign sel_duty[i] = sel;
    always_comb begin
      case (b)
        fan_mux_pkg::SRC_REMOTE1: base = demand.remote1;
        fan_mux_pkg::SRC_LOCAL: base = demand.local_ch;
        fan_mux_pkg::SRC_REMOTE2: base = demand.remote2;
        fan_mux_pkg::SRC_MAX_LR2: base = max_lr2;
        fan_mux_pkg::SRC_MAX_ALL: base = max_all;
        fan_mux_pkg::SRC_FULL: base = `DUTY_FULL;
        fan_mux_pkg::SRC_OFF: base = `DUTY_OFF;
        fan_mux_pkg::SRC_MANUAL: base = s_q.duty[i];
        default: base = `DUTY_OFF;
      endcase
      // Override beats a lower duty in every mode except disabled, manual included
      if (thermal_limit_signal_hit[i] && b != fan_mux_pkg::SRC_OFF && boost > base) begin
        sel = boost;
      end else begin
        sel = base;
      end
    end
  end

  always_comb begin
    s_d = s_q;
    // Two-stage synchroniser; first stage read only by the second
    s_d.thermal_limit_signal_meta = over_limit;
    s_d.thermal_limit_signal_sync = s_q.thermal_limit_signal_meta;
    s_d.rvalid = 1'b0;
    for (int i = 0; i < `NUM_DRIVES; i++) begin
      // Duty latched at period start, but manual duty writes land mid-period and can cut a pulse
      if (s_q.cnt[i] == `PERIOD_LAST) begin
        s_d.cnt[i] = `DUTY_OFF;
        // Automatic modes refresh every period on their own
        if (!is_manual[i] || thermal_limit_signal_hit[i]) begin
          s_d.duty[i] = sel_duty[i];
        end
      end else begin
        s_d.cnt[i] = s_q.cnt[i] + 8'h01;
      end
    end
    if (req.wr) begin
      case (req.addr)
        `CFG1_OFS: s_d.cfg[0] = req.wdata;
        `CFG2_OFS: s_d.cfg[1] = req.wdata;
        `CFG3_OFS: s_d.cfg[2] = req.wdata;
        // Writes only land in manual mode; otherwise dropped
        `DUTY1_OFS: if (is_manual[0])
          s_d.duty[0] = req.wdata;
        `DUTY2_OFS: if (is_manual[1])
          s_d.duty[1] = req.wdata;
        `DUTY3_OFS: if (is_manual[2])
          s_d.duty[2] = req.wdata;
        default: ;
      endcase
    end
    if (req.rd) begin
      s_d.rvalid = 1'b1;
      case (req.addr)
        `CFG1_OFS: s_d.rdata = s_q.cfg[0];
        `CFG2_OFS: s_d.rdata = s_q.cfg[1];
        `CFG3_OFS: s_d.rdata = s_q.cfg[2];
        `DUTY1_OFS: s_d.rdata = s_q.duty[0];
        `DUTY2_OFS: s_d.rdata = s_q.duty[1];
        `DUTY3_OFS: s_d.rdata = s_q.duty[2];
        default: s_d.rdata = `DUTY_OFF;
      endcase
    end
    // 255 counts per period: 0xFF is a solid high, 0x00 solid low
    // Next count and duty, so output never lags the applied duty
    for (int i = 0; i < `NUM_DRIVES; i++) begin
      s_d.drive[i] = (s_d.cnt[i] < s_d.duty[i]);
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      s_q.cfg <= {`CFG_RESET, `CFG_RESET, `CFG_RESET};
      s_q.duty <= {`DUTY_RESET, `DUTY_RESET, `DUTY_RESET};
      // Parked at period end: first edge loads the disabled duty at once
      s_q.cnt <= {`PERIOD_LAST, `PERIOD_LAST, `PERIOD_LAST};
      s_q.drive <= '0;
      s_q.rdata <= '0;
      s_q.rvalid <= 1'b0;
      s_q.thermal_limit_signal_meta <= '0;
      s_q.thermal_limit_signal_sync <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign rdata = s_q.rdata;
  assign rvalid = s_q.rvalid;
  assign fan_drive_one = s_q.drive[0];
  assign fan_drive_two = s_q.drive[1];
  assign fan_drive_three = s_q.drive[2];
endmodule

// file: hw/fan_mux_map.svh
// Register map and constants for the fan drive source selector.
// Assumes inclusion by the design file by bare name.
`ifndef FAN_MUX_MAP_SVH
`define FAN_MUX_MAP_SVH
`define DUTY1_OFS 8'h30
`define DUTY2_OFS 8'h31
`define DUTY3_OFS 8'h32
`define CFG1_OFS 8'h5C
`define CFG2_OFS 8'h5D
`define CFG3_OFS 8'h5E
`define BEHAVIOUR_SELECT_HI 7
`define BEHAVIOUR_SELECT_LO 5
`define BEHAVIOUR_SELECT_DISABLED 3'h4
`define CFG_RESET 8'h80
`define DUTY_RESET 8'hFF
`define DUTY_FULL 8'hFF
`define DUTY_OFF 8'h00
`define PERIOD_LAST 8'hFE
`define NUM_DRIVES 3
`endif

// file: hw/fan_mux_pkg.sv
// Types shared by the fan drive source selector.
// Assumes fan_mux_map.svh is on the include path.
package fan_mux_pkg;
  typedef enum logic [2:0] {
    SRC_REMOTE1 = 3'h0,
    SRC_LOCAL = 3'h1,
    SRC_REMOTE2 = 3'h2,
    SRC_FULL = 3'h3,
    SRC_OFF = 3'h4,
    SRC_MAX_LR2 = 3'h5,
    SRC_MAX_ALL = 3'h6,
    SRC_MANUAL = 3'h7
  } behaviour_t;

  typedef struct packed {
    logic [7:0] remote1;
    logic [7:0] local_ch;
    logic [7:0] remote2;
  } demand_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic [2:0][7:0] cfg;
    logic [2:0][7:0] duty;
    logic [2:0][7:0] cnt;
    logic [2:0] drive;
    logic [7:0] rdata;
    logic rvalid;
    logic [2:0] thermal_limit_signal_meta;
    logic [2:0] thermal_limit_signal_sync;
  } state_t;
endpackage
